//--- rtl/haptic_drive_mode_control.sv
/*
 * Device end: haptic mode control register, mode decode, PWM duty
 * measurement, real-time amplitude and pattern start/stop sequencing.
 * Assumes register accesses and pins are synchronous to i_clk.
 */
// Function
// R1 - bit 7 write of 1 triggers RAM vibration
// R2 - bit 6 enables pattern RAM block
// R3 - host sets clock enable before nonzero mode
// R4 - bits 4:0 select mode; zero disables
// R5 - codes 1..5 measure PWM on pin 0..4
// R6 - code 6 follows real-time amplitude register
// R7 - codes 7..11 pin pulse starts stored pattern
// R8 - codes 13..18 pin pulse starts RAM pattern
// R9 - amplitude sign in MSB, start positive
// R10 - RAM playback starts at start address register
// R11 - unassigned codes act as disabled
// R12 - writing disable code stops vibration immediately
module haptic_drive_mode_control
    import haptic_mode_pkg::*;
#(
    parameter int PWM_WINDOW = PWM_WINDOW_CYCLES,
    parameter int SAMPLE_LEN = SAMPLE_CYCLES,
    parameter int PATTERN_LEN = PATTERN_SAMPLES
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    haptic_link_if.device link,
    input wire logic [7:0] i_ram_sample,
    output logic o_drive_on,
    output logic [7:0] o_amplitude,
    output logic o_ram_read,
    output logic [7:0] o_ram_addr,
    output logic [2:0] o_mode_kind
);
    if (PWM_WINDOW < 1 || PWM_WINDOW > 255 || SAMPLE_LEN < 1 || PATTERN_LEN < 1 || PATTERN_LEN > 256) begin
        $error("haptic_drive_mode_control: parameter out of range");
    end

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PLAY = 2'b01
    } play_state_t;

    // ========================================
    // mode decode
    function automatic mode_kind_t kind_of(input logic [4:0] mode);
        if (mode >= MODE_PWM_FIRST && mode <= MODE_PWM_LAST) begin
            return KIND_PWM; // R5
        end else if (mode == MODE_REALTIME) begin
            return KIND_REALTIME; // R6
        end else if (mode >= MODE_PIN_FIRST && mode <= MODE_PIN_LAST) begin
            return KIND_PIN_STORED; // R7
        end else if (mode >= MODE_RAM_FIRST && mode <= MODE_RAM_LAST) begin
            return KIND_RAM; // R8
        end else begin
            return KIND_OFF; // R4 R11
        end
    endfunction : kind_of

    // ram modes have six codes over five pins; the sixth reuses pin 4
    function automatic logic [2:0] pin_of(input logic [4:0] mode);
        logic [4:0] idx;
        idx = 5'h00;
        case (kind_of(mode))
            KIND_PWM: idx = mode - MODE_PWM_FIRST;
            KIND_PIN_STORED: idx = mode - MODE_PIN_FIRST;
            KIND_RAM: idx = mode - MODE_RAM_FIRST;
            default: idx = 5'h00;
        endcase
        if (idx > 5'h04) begin
            idx = 5'h04;
        end
        return idx[2:0];
    endfunction : pin_of

    logic [7:0] control;
    logic [7:0] rt_amplitude;
    logic [7:0] start_address;
    logic [4:0] pin_prev;
    logic [7:0] pwm_count;
    logic [7:0] pwm_high;
    logic [7:0] pwm_duty;
    logic rt_armed;
    play_state_t state;
    logic [$clog2(SAMPLE_LEN + 1)-1:0] sample_tick;
    logic [8:0] samples_done;
    logic [7:0] play_addr;

    logic wr_control;
    logic soft_trigger;
    logic [4:0] mode;
    mode_kind_t kind;
    logic [2:0] pin_sel;
    logic pin_rise;
    logic clk_on;
    logic start_play;
    logic sample_end;

    assign wr_control = link.reg_wr && link.reg_addr == ADDR_MODE_CONTROL;
    assign soft_trigger = wr_control && link.reg_wdata[BIT_SOFT_TRIGGER] && link.reg_wdata[BIT_RAM_ENABLE]
        && link.reg_wdata[BIT_CLOCK_ENABLE] && kind_of(link.reg_wdata[MODE_MSB:0]) == KIND_RAM; // R1
    assign mode = control[MODE_MSB:0]; // R4
    assign kind = kind_of(mode);
    assign pin_sel = pin_of(mode);
    assign pin_rise = link.multi_purpose_pin[pin_sel] && !pin_prev[pin_sel];
    // without the drive clock nothing runs, so a host that skips it gets silence
    assign clk_on = control[BIT_CLOCK_ENABLE]; // R3
    // trigger judged on the written value, so one write can enable and fire
    assign start_play = state == ST_IDLE && (soft_trigger || clk_on
        && ((kind == KIND_PIN_STORED && pin_rise) // R7
        || (kind == KIND_RAM && control[BIT_RAM_ENABLE] && pin_rise))); // R8 R2
    assign sample_end = sample_tick == ($clog2(SAMPLE_LEN + 1))'(SAMPLE_LEN - 1);

    // ========================================
    // registers
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            control <= RESET_MODE_CONTROL;
            rt_amplitude <= RESET_RT_AMPLITUDE;
            start_address <= RESET_START_ADDRESS;
        end else if (link.reg_wr) begin
            case (link.reg_addr)
                ADDR_MODE_CONTROL: control <= link.reg_wdata;
                ADDR_RT_AMPLITUDE: rt_amplitude <= link.reg_wdata;
                ADDR_START_ADDRESS: start_address <= link.reg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            link.reg_rdata <= 8'h00;
        end else if (link.reg_rd) begin
            case (link.reg_addr)
                ADDR_MODE_CONTROL: link.reg_rdata <= control;
                ADDR_RT_AMPLITUDE: link.reg_rdata <= rt_amplitude;
                ADDR_START_ADDRESS: link.reg_rdata <= start_address;
                default: link.reg_rdata <= 8'h00;
            endcase
        end
    end

    // ========================================
    // pwm duty measurement over a fixed window
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pin_prev <= 5'h00;
            pwm_count <= 8'h00;
            pwm_high <= 8'h00;
            pwm_duty <= 8'h00;
        end else begin
            pin_prev <= link.multi_purpose_pin;
            if (kind != KIND_PWM || !clk_on) begin
                pwm_count <= 8'h00;
                pwm_high <= 8'h00;
                pwm_duty <= 8'h00;
            end else if (pwm_count == 8'(PWM_WINDOW - 1)) begin
                pwm_count <= 8'h00;
                pwm_high <= 8'h00;
                pwm_duty <= pwm_high + 8'(link.multi_purpose_pin[pin_sel]); // R5
            end else begin
                pwm_count <= pwm_count + 8'h01;
                pwm_high <= pwm_high + 8'(link.multi_purpose_pin[pin_sel]);
            end
        end
    end

    // real-time output holds off until the first positive value
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rt_armed <= 1'b0;
        end else if (kind != KIND_REALTIME || !clk_on) begin
            rt_armed <= 1'b0;
        end else if (!rt_amplitude[AMP_SIGN_BIT]) begin
            rt_armed <= 1'b1; // R9
        end
    end

    // ========================================
    // pattern playback
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state <= ST_IDLE;
            sample_tick <= '0;
            samples_done <= 9'h000;
            play_addr <= 8'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start_play) begin
                        state <= ST_PLAY;
                        sample_tick <= '0;
                        samples_done <= 9'h000;
                        play_addr <= start_address; // R10
                    end
                end
                ST_PLAY: begin
                    if (kind != KIND_PIN_STORED && kind != KIND_RAM || !clk_on) begin
                        state <= ST_IDLE; // R12 R11
                    end else if (sample_end) begin
                        sample_tick <= '0;
                        play_addr <= play_addr + 8'h01;
                        samples_done <= samples_done + 9'h001;
                        if (samples_done == 9'(PATTERN_LEN - 1)) begin
                            state <= ST_IDLE;
                        end
                    end else begin
                        sample_tick <= sample_tick + 1'b1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ========================================
    // outputs
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_drive_on <= 1'b0;
            o_amplitude <= 8'h00;
        end else if (!clk_on) begin
            o_drive_on <= 1'b0;
            o_amplitude <= 8'h00;
        end else begin
            case (kind)
                KIND_PWM: begin
                    o_drive_on <= 1'b1;
                    o_amplitude <= pwm_duty;
                end
                KIND_REALTIME: begin
                    o_drive_on <= rt_armed || !rt_amplitude[AMP_SIGN_BIT];
                    o_amplitude <= (rt_armed || !rt_amplitude[AMP_SIGN_BIT]) ? rt_amplitude : 8'h00; // R6 R9
                end
                KIND_PIN_STORED: begin
                    o_drive_on <= state == ST_PLAY;
                    o_amplitude <= state == ST_PLAY ? STORED_LEVEL : 8'h00;
                end
                KIND_RAM: begin
                    o_drive_on <= state == ST_PLAY;
                    o_amplitude <= state == ST_PLAY ? i_ram_sample : 8'h00;
                end
                default: begin
                    o_drive_on <= 1'b0; // R4 R11
                    o_amplitude <= 8'h00;
                end
            endcase
        end
    end

    assign o_ram_read = state == ST_PLAY && kind == KIND_RAM && control[BIT_RAM_ENABLE]; // R2
    assign o_ram_addr = play_addr;
    assign o_mode_kind = kind;
endmodule : haptic_drive_mode_control

//--- rtl/haptic_mode_pkg.sv
/*
 * Shared constants for the haptic drive mode control link: register
 * offsets, field positions, mode codes and cycle counts.
 * Assumes a single 50 MHz clock shared by both ends.
 */
package haptic_mode_pkg;
    // ========================================
    // register map
    localparam logic [7:0] ADDR_MODE_CONTROL = 8'h09;
    localparam logic [7:0] ADDR_RT_AMPLITUDE = 8'h0A;
    localparam logic [7:0] ADDR_START_ADDRESS = 8'h0B;
    localparam logic [7:0] RESET_MODE_CONTROL = 8'h00;
    localparam logic [7:0] RESET_RT_AMPLITUDE = 8'h00;
    localparam logic [7:0] RESET_START_ADDRESS = 8'h00;
    // ========================================
    // fields of haptic_mode_control
    localparam int BIT_SOFT_TRIGGER = 7;
    localparam int BIT_RAM_ENABLE = 6;
    localparam int BIT_CLOCK_ENABLE = 5;
    localparam int MODE_MSB = 4;
    localparam int AMP_SIGN_BIT = 7;
    // ========================================
    // mode codes
    localparam logic [4:0] MODE_DISABLED = 5'h00;
    localparam logic [4:0] MODE_PWM_FIRST = 5'h01;
    localparam logic [4:0] MODE_PWM_LAST = 5'h05;
    localparam logic [4:0] MODE_REALTIME = 5'h06;
    localparam logic [4:0] MODE_PIN_FIRST = 5'h07;
    localparam logic [4:0] MODE_PIN_LAST = 5'h0B;
    localparam logic [4:0] MODE_RAM_FIRST = 5'h0D;
    localparam logic [4:0] MODE_RAM_LAST = 5'h12;
    localparam int NUM_PINS = 5;
    // ========================================
    // cycle counts
    localparam int PWM_WINDOW_CYCLES = 255;
    localparam int SAMPLE_CYCLES = 16;
    localparam int PATTERN_SAMPLES = 32;
    localparam logic [7:0] STORED_LEVEL = 8'h40;
    localparam int PULSE_CYCLES = 4;

    typedef enum logic [2:0] {
        KIND_OFF = 3'b000,
        KIND_PWM = 3'b001,
        KIND_REALTIME = 3'b011,
        KIND_PIN_STORED = 3'b010,
        KIND_RAM = 3'b110
    } mode_kind_t;
endpackage : haptic_mode_pkg

//--- rtl/haptic_link_if.sv
/*
 * Link between the host and the haptic driver: a synchronous register
 * port and the five multipurpose pins.
 * Assumes both ends share i_clk.
 */
interface haptic_link_if;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [4:0] multi_purpose_pin;

    modport device (
        input reg_wr,
        input reg_rd,
        input reg_addr,
        input reg_wdata,
        output reg_rdata,
        input multi_purpose_pin
    );
    modport host (
        output reg_wr,
        output reg_rd,
        output reg_addr,
        output reg_wdata,
        input reg_rdata,
        output multi_purpose_pin
    );
endinterface : haptic_link_if

//--- rtl/haptic_host_end.sv
/*
 * Host end: issues register accesses, keeps the drive clock enable in
 * step with the mode, and drives PWM or start pulses on the pins.
 * Assumes one request at a time, taken while o_busy is low.
 */
module haptic_host_end
    import haptic_mode_pkg::*;
#(
    parameter int PULSE_LEN = PULSE_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    haptic_link_if.host link,
    input wire logic i_wr_req,
    input wire logic i_rd_req,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic o_busy,
    output logic [7:0] o_rdata,
    output logic o_rd_valid,
    input wire logic [2:0] i_pin_sel,
    input wire logic i_pwm_on,
    input wire logic [7:0] i_pwm_duty,
    input wire logic i_pulse_req
);
    if (PULSE_LEN < 1 || PULSE_LEN > 255) begin
        $error("haptic_host_end: PULSE_LEN out of range");
    end

    logic [7:0] shadow;
    logic pending;
    logic [7:0] pending_data;
    logic rd_wait;
    logic [7:0] pwm_count;
    logic [7:0] pulse_count;
    logic [7:0] next_wdata;
    logic two_step;
    logic is_ctrl;

    // clock enable rides along with any nonzero mode
    assign is_ctrl = i_addr == ADDR_MODE_CONTROL;
    always_comb begin
        next_wdata = i_wdata;
        if (is_ctrl && i_wdata[MODE_MSB:0] != MODE_DISABLED) begin
            next_wdata[BIT_CLOCK_ENABLE] = 1'b1; // R3
        end
    end
    // stopping: mode to zero first, clock enable off on a second write
    assign two_step = is_ctrl && i_wdata[MODE_MSB:0] == MODE_DISABLED && !i_wdata[BIT_CLOCK_ENABLE]
        && shadow[BIT_CLOCK_ENABLE] && shadow[MODE_MSB:0] != MODE_DISABLED; // R3
    assign o_busy = pending || rd_wait;

    // ========================================
    // register port
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            link.reg_wr <= 1'b0;
            link.reg_rd <= 1'b0;
            link.reg_addr <= 8'h00;
            link.reg_wdata <= 8'h00;
            shadow <= RESET_MODE_CONTROL;
            pending <= 1'b0;
            pending_data <= 8'h00;
            rd_wait <= 1'b0;
        end else begin
            link.reg_wr <= 1'b0;
            link.reg_rd <= 1'b0;
            rd_wait <= link.reg_rd;
            if (pending) begin
                link.reg_wr <= 1'b1;
                link.reg_wdata <= pending_data;
                shadow <= pending_data;
                pending <= 1'b0;
            end else if (i_wr_req && !rd_wait) begin
                link.reg_wr <= 1'b1;
                link.reg_addr <= i_addr;
                if (two_step) begin
                    link.reg_wdata <= {i_wdata[7:6], 1'b1, MODE_DISABLED};
                    shadow <= {i_wdata[7:6], 1'b1, MODE_DISABLED};
                    pending <= 1'b1;
                    pending_data <= i_wdata;
                end else begin
                    link.reg_wdata <= next_wdata;
                    if (is_ctrl) begin
                        shadow <= next_wdata;
                    end
                end
            end else if (i_rd_req && !rd_wait) begin
                link.reg_rd <= 1'b1;
                link.reg_addr <= i_addr;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rdata <= 8'h00;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= rd_wait;
            if (rd_wait) begin
                o_rdata <= link.reg_rdata;
            end
        end
    end

    // ========================================
    // pins: pwm with a 255-cycle period, or a start pulse
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pwm_count <= 8'h00;
            pulse_count <= 8'h00;
            link.multi_purpose_pin <= 5'h00;
        end else begin
            pwm_count <= pwm_count == 8'(PWM_WINDOW_CYCLES - 1) ? 8'h00 : pwm_count + 8'h01;
            if (i_pulse_req && pulse_count == 8'h00) begin
                pulse_count <= 8'(PULSE_LEN);
            end else if (pulse_count != 8'h00) begin
                pulse_count <= pulse_count - 8'h01;
            end
            for (int i = 0; i < NUM_PINS; i++) begin
                link.multi_purpose_pin[i] <= i_pin_sel == 3'(i)
                    && ((i_pwm_on && pwm_count < i_pwm_duty) || pulse_count != 8'h00); // R7 R8
            end
        end
    end
endmodule : haptic_host_end

//--- tb/haptic_link_checker.sv
/*
 * Checker on the haptic link: mode decode, control register readback, clock
 * enable order, pin-stored pattern start timing and drive stop on disable.
 * Assumes the link signals and device outputs of the bench, one clock.
 */
module haptic_link_checker
    import haptic_mode_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [4:0] multi_purpose_pin,
    input wire logic o_drive_on,
    input wire logic [7:0] o_amplitude,
    input wire logic [2:0] o_mode_kind
);
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================
    // shadow of the control register
    logic [7:0] ctl;
    logic [4:0] md;
    logic wr_ctl;
    logic sel_pin;
    logic unas;
    assign md = ctl[MODE_MSB:0];
    assign wr_ctl = reg_wr && reg_addr == ADDR_MODE_CONTROL;
    // index only meaningful in pin-stored modes, where the properties use it
    assign sel_pin = multi_purpose_pin[3'(md - MODE_PIN_FIRST)];
    assign unas = md == 5'h0C || md > MODE_RAM_LAST;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctl <= RESET_MODE_CONTROL;
        end else if (wr_ctl) begin
            ctl <= reg_wdata;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // ========================================
    // properties
    property p_off; md == MODE_DISABLED |-> o_mode_kind == KIND_OFF; endproperty
    property p_pwm; md inside {[MODE_PWM_FIRST:MODE_PWM_LAST]} |-> o_mode_kind == KIND_PWM; endproperty
    property p_rt; md == MODE_REALTIME |-> o_mode_kind == KIND_REALTIME; endproperty
    property p_pin; md inside {[MODE_PIN_FIRST:MODE_PIN_LAST]} |-> o_mode_kind == KIND_PIN_STORED; endproperty
    property p_ram; md inside {[MODE_RAM_FIRST:MODE_RAM_LAST]} |-> o_mode_kind == KIND_RAM; endproperty
    // registered output lags the decode by one edge
    property p_unas; unas [*3] |-> o_mode_kind == KIND_OFF && !o_drive_on; endproperty
    property p_stop; wr_ctl && reg_wdata[4:0] == MODE_DISABLED |-> ##2 !o_drive_on; endproperty
    property p_read; reg_rd && !reg_wr && reg_addr == ADDR_MODE_CONTROL |=> reg_rdata == $past(ctl); endproperty
    property p_clk_on; wr_ctl && reg_wdata[4:0] != MODE_DISABLED |-> reg_wdata[BIT_CLOCK_ENABLE]; endproperty
    property p_clk_off; wr_ctl && !reg_wdata[BIT_CLOCK_ENABLE] |-> md == MODE_DISABLED; endproperty
    property p_pin_start;
        md inside {[MODE_PIN_FIRST:MODE_PIN_LAST]} && ctl[BIT_CLOCK_ENABLE] && !o_drive_on && $rose(sel_pin)
            |-> ##[1:4] o_drive_on;
    endproperty
    a_off: assert property (p_off) else $error("off decode wrong");
    a_pwm: assert property (p_pwm) else $error("pwm decode wrong");
    a_rt: assert property (p_rt) else $error("realtime decode wrong");
    a_pin: assert property (p_pin) else $error("pin decode wrong");
    a_ram: assert property (p_ram) else $error("ram decode wrong");
    a_unas: assert property (p_unas) else $error("unassigned code not off");
    a_stop: assert property (p_stop) else $error("drive not stopped");
    a_read: assert property (p_read) else $error("control readback wrong");
    a_clk_on: assert property (p_clk_on) else $error("mode without clock");
    a_clk_off: assert property (p_clk_off) else $error("clock off before mode off");
    a_pin_start: assert property (p_pin_start) else $error("pin pulse no start");
    c_rt: cover property (o_mode_kind == KIND_REALTIME && o_amplitude != 8'h00);
    c_ram: cover property (o_mode_kind == KIND_RAM && o_drive_on);
    c_stop: cover property (wr_ctl && reg_wdata == 8'h20 && o_drive_on);
endmodule : haptic_link_checker

//--- tb/tb_top.sv
/*
 * Bench joining host end and device end over the link; a register
 * model in the bench predicts every read; outputs are checked against values the bench works out from what it wrote.
 * Assumes one 50 MHz clock and shortened pattern and window counts.
 */
module tb_top import haptic_mode_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PW = 15;
    localparam int SL = 3;
    localparam int PL = 4;
    logic i_clk, i_sys_rst, i_wr_req, i_rd_req, o_busy, o_rd_valid, i_pwm_on, i_pulse_req;
    logic o_drive_on, o_ram_read;
    logic [7:0] i_addr, i_wdata, o_rdata, i_pwm_duty, i_ram_sample, o_amplitude, o_ram_addr;
    logic [2:0] i_pin_sel, o_mode_kind;
    logic [7:0] mdl [0:2];
    logic [31:0] v;
    int seed, num_errors, cmp_count;
    haptic_link_if u_haptic_link_if ();
    haptic_drive_mode_control #(.PWM_WINDOW(PW), .SAMPLE_LEN(SL), .PATTERN_LEN(PL)) u_haptic_drive_mode_control (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .link(u_haptic_link_if.device), .i_ram_sample(i_ram_sample),
        .o_drive_on(o_drive_on), .o_amplitude(o_amplitude), .o_ram_read(o_ram_read), .o_ram_addr(o_ram_addr),
        .o_mode_kind(o_mode_kind));
    haptic_host_end #(.PULSE_LEN(4)) u_haptic_host_end (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .link(u_haptic_link_if.host), .i_wr_req(i_wr_req),
        .i_rd_req(i_rd_req), .i_addr(i_addr), .i_wdata(i_wdata), .o_busy(o_busy), .o_rdata(o_rdata),
        .o_rd_valid(o_rd_valid), .i_pin_sel(i_pin_sel), .i_pwm_on(i_pwm_on), .i_pwm_duty(i_pwm_duty),
        .i_pulse_req(i_pulse_req));
    haptic_link_checker u_haptic_link_checker (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .reg_wr(u_haptic_link_if.reg_wr),
        .reg_rd(u_haptic_link_if.reg_rd), .reg_addr(u_haptic_link_if.reg_addr),
        .reg_wdata(u_haptic_link_if.reg_wdata), .reg_rdata(u_haptic_link_if.reg_rdata),
        .multi_purpose_pin(u_haptic_link_if.multi_purpose_pin), .o_drive_on(o_drive_on),
        .o_amplitude(o_amplitude), .o_mode_kind(o_mode_kind));
    always #10 i_clk = ~i_clk;
    // pattern memory stand-in: data follows the address so a stuck address shows
    always @(negedge i_clk) i_ram_sample <= o_ram_addr ^ 8'hA5;
    // ========================================
    // tasks
    function automatic logic [2:0] kind_of(input logic [4:0] m);
        if (m >= 5'h01 && m <= 5'h05) return KIND_PWM;
        if (m == 5'h06) return KIND_REALTIME;
        if (m >= 5'h07 && m <= 5'h0B) return KIND_PIN_STORED;
        if (m >= 5'h0D && m <= 5'h12) return KIND_RAM;
        return KIND_OFF;
    endfunction : kind_of
    function automatic logic [7:0] cur(input int sel);
        if (sel == 0) return {7'h00, o_drive_on};
        if (sel == 1) return o_amplitude;
        return {7'h00, o_ram_read};
    endfunction : cur
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic free();
        int k;
        k = 0;
        @(negedge i_clk);
        while (o_busy !== 1'b0 && k < 50) begin
            @(negedge i_clk);
            k++;
        end
        if (o_busy !== 1'b0) begin
            num_errors++;
            close_out();
        end
    endtask : free
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        free();
        i_addr = a;
        i_wdata = d;
        i_wr_req = 1'b1;
        @(negedge i_clk);
        i_wr_req = 1'b0;
        if (a >= 8'h09 && a <= 8'h0B) mdl[a - 8'h09] = (a == 8'h09 && d[4:0] != 5'h00) ? (d | 8'h20) : d;
        free();
        repeat (3) @(negedge i_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int k;
        k = 0;
        free();
        i_addr = a;
        i_rd_req = 1'b1;
        @(negedge i_clk);
        i_rd_req = 1'b0;
        while (o_rd_valid !== 1'b1 && k < 20) begin
            @(negedge i_clk);
            k++;
        end
        check("rdata", o_rdata, (a >= 8'h09 && a <= 8'h0B) ? mdl[a - 8'h09] : 8'h00);
        if (o_rd_valid !== 1'b1) begin
            num_errors++;
            close_out();
        end
        repeat (2) @(negedge i_clk);
    endtask : rd
    task automatic wait_for(input int sel, input logic [7:0] val, input int n);
        int k;
        k = 0;
        while (cur(sel) !== val && k < n) begin
            @(negedge i_clk);
            k++;
        end
        check(sel == 0 ? "drive_on" : sel == 1 ? "amplitude" : "ram_read", cur(sel), val);
        if (cur(sel) !== val) close_out();
    endtask : wait_for
    task automatic pulse(input int p);
        @(negedge i_clk);
        i_pin_sel = 3'(p);
        i_pulse_req = 1'b1;
        @(negedge i_clk);
        i_pulse_req = 1'b0;
    endtask : pulse
    // ========================================
    // main sequence
    initial begin
        {i_clk, i_wr_req, i_rd_req, i_pwm_on, i_pulse_req} = 5'h00;
        {i_addr, i_wdata, i_pwm_duty, i_pin_sel} = 27'h0;
        {mdl[0], mdl[1], mdl[2]} = 24'h0;
        seed = 15508;
        num_errors = 0;
        cmp_count = 0;
        i_sys_rst = 1'b1;
        repeat (4) @(posedge i_clk);
        @(negedge i_clk);
        i_sys_rst = 1'b0;
        wr(8'h0C, 8'hFF);
        for (int a = 9; a <= 12; a++) rd(8'(a));
        $display("reset and unmapped done");
        for (int c = 0; c < 32; c++) begin
            v = $random(seed);
            wr(8'h09, {v[7:5], 5'(c)});
            check("mode_kind", {5'h00, o_mode_kind}, {5'h00, kind_of(5'(c))});
            rd(8'h09);
        end
        wr(8'h09, 8'h00);
        $display("mode decode done");
        i_pwm_on = 1'b1;
        for (int p = 0; p < 5; p++) begin
            v = $random(seed);
            i_pin_sel = (p % 2 == 1) ? 3'(p) : 3'((p + 1) % 5);
            i_pwm_duty = (p % 2 == 1) ? 8'hFF : v[7:0];
            wr(8'h09, 8'(8'h20 + p + 1));
            repeat (3 * PW) @(negedge i_clk);
            check("pwm_amp", o_amplitude, (p % 2 == 1) ? 8'(PW) : 8'h00);
        end
        i_pwm_on = 1'b0;
        $display("pwm done");
        for (int p = 0; p < 5; p++) begin
            wr(8'h09, 8'(8'h27 + p));
            pulse((p + 1) % 5);
            repeat (8) @(negedge i_clk);
            check("wrong_pin", {7'h00, o_drive_on}, 8'h00);
            pulse(p);
            wait_for(0, 8'h01, 8);
            wait_for(1, STORED_LEVEL, 4);
            wait_for(0, 8'h00, 2 * PL * SL + 4);
        end
        $display("stored pattern done");
        for (int c = 13; c <= 18; c++) begin
            v = $random(seed);
            wr(8'h0B, v[7:0]);
            wr(8'h09, 8'(8'h60 + c));
            pulse(c == 18 ? 4 : c - 13);
            wait_for(2, 8'h01, 8);
            check("start_addr", o_ram_addr, v[7:0]);
            wait_for(1, v[7:0] ^ 8'hA5, 4);
            wait_for(0, 8'h00, 2 * PL * SL + 4);
        end
        wr(8'h09, 8'h2D);
        pulse(0);
        repeat (8) @(negedge i_clk);
        check("ram_off", {7'h00, o_drive_on}, 8'h00);
        wr(8'h09, 8'hED);
        wait_for(0, 8'h01, 4);
        wr(8'h09, 8'h20);
        check("stopped", {7'h00, o_drive_on}, 8'h00);
        $display("ram pattern done");
        v = $random(seed);
        wr(8'h0A, v[7:0] | 8'h80);
        wr(8'h09, 8'h26);
        check("rt_neg_first", o_amplitude, 8'h00);
        wr(8'h0A, v[15:8] & 8'h7F);
        wait_for(1, v[15:8] & 8'h7F, 6);
        wr(8'h0A, v[23:16] | 8'h80);
        wait_for(1, v[23:16] | 8'h80, 6);
        wr(8'h09, 8'h00);
        rd(8'h0A);
        rd(8'h09);
        $display("realtime done");
        close_out();
    end
endmodule : tb_top
